/* rtl/adc_ctrl_params.svh */
// register offsets, field positions and reset values of the converter control block
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

// register indices; byte address is four times the index
`define IDX_INPUT_SELECT 6'h00
`define IDX_GATE_LOW 6'h01
`define IDX_GATE_HIGH 6'h02
`define IDX_CONTROL 6'h03
`define IDX_RESULT_LOW 6'h04
`define IDX_RESULT_HIGH 6'h05
`define IDX_PIN_VALUE 6'h06

// control register field positions
`define CTL_ENABLE_BIT 7
`define CTL_START_BIT 6
`define CTL_AUTO_BIT 5
`define CTL_FLAG_BIT 4
`define CTL_TSRC_MSB 2
`define CTL_TSRC_LSB 0

// high gate register: writable upper nibble
`define GATE_HIGH_MSB 7
`define GATE_HIGH_LSB 4
// low gate register: reference pin bit
`define GATE_LOW_REF_BIT 3

// reset values
`define RST_INPUT_SELECT 6'h00
`define RST_GATE_LOW 8'h00
`define RST_GATE_HIGH 4'h0
`define RST_RESULT 10'h000

// channel code that routes the temperature sensor
`define TEMP_SENSOR_CODE 6'h3F
// result high byte shift
`define RESULT_HIGH_SHIFT 8

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* rtl/adc_ctrl_pkg.sv */
// types shared by the converter control block
package adc_ctrl_pkg;

  typedef enum logic [2:0] {
    TRIG_FREE_RUN = 3'b000,
    TRIG_COMPARATOR = 3'b001,
    TRIG_EXT_IRQ0 = 3'b010,
    TRIG_T0_CMP_A = 3'b011,
    TRIG_T0_OVF = 3'b100,
    TRIG_T0_CMP_B = 3'b101,
    TRIG_T1_OVF = 3'b110,
    TRIG_WDT_IRQ = 3'b111
  } trig_src_t;

  typedef enum logic [0:0] {
    CONV_IDLE = 1'b0,
    CONV_BUSY = 1'b1
  } conv_state_t;

  typedef struct packed {
    logic wdt_irq;
    logic t1_ovf;
    logic t0_cmp_b;
    logic t0_ovf;
    logic t0_cmp_a;
    logic ext_irq0;
    logic comparator;
  } trig_in_t;

  typedef struct packed {
    logic [7:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } axi_rsp_t;

endpackage

/* rtl/trig_edge_sel.sv */
// trigger source selector with rising edge detector
`timescale 1ns/1ps
module trig_edge_sel
  import adc_ctrl_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_src,
  input wire trig_src_t i_sel,
  output logic o_pulse
);

  typedef struct packed {
    logic [7:0] prev;
  } edge_state_t;

  edge_state_t st_q;
  edge_state_t st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.prev = i_src;
  end

  // previous level kept per source, so a source change never fakes an edge
  assign o_pulse = i_src[i_sel] & ~st_q.prev[i_sel];

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      st_q <= '0;
    end
    else
    begin
      st_q <= st_d;
    end
  end

endmodule

/* rtl/adc_trigger_ctrl.sv */
// converter trigger, channel select and pin input gating with AXI4-Lite registers
// Operation
// - all-ones channel code routes and enables the temperature sensor
// - sensor channel is measured by an ordinary single conversion
// - three-bit trigger source field decodes to eight documented sources
// - triggers start conversions only while the converter enable bit is set
// - switching to free running never produces a trigger by itself
// - low gate bits 7:4 and 2:0 disable pins six to zero, reading zero
// - low gate bit 3 disables reference pin input, reading zero
// - high gate bits 7:4 gate pins ten to seven; 3:0 read zero
// - ten-bit result readable as high byte and low byte
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
module adc_trigger_ctrl
  import adc_ctrl_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire axi_req_t I_AXI,
  output axi_rsp_t O_AXI,
  input wire trig_in_t I_TRIG,
  input wire logic I_CONV_DONE,
  input wire logic [9:0] I_CONV_RESULT,
  input wire logic [10:0] I_PIN_RAW,
  input wire logic I_REF_PIN_RAW,
  output logic O_CONV_START,
  output logic O_CONV_BUSY,
  output logic [5:0] O_CHANNEL,
  output logic O_TEMP_SENSOR_EN,
  output logic [11:0] O_BUF_DISABLE,
  output logic [11:0] O_PIN_VALUE
);

  // ************************************************************
  // state
  // ************************************************************

  typedef struct packed {
    logic aw_full;
    logic [7:0] aw_addr;
    logic w_full;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [5:0] channel_select_field;
    logic [7:0] analog_pin_input_gate_low;
    logic [3:0] high_pin_gate_bits;
    logic converter_enable_bit;
    logic start;
    logic auto_trig;
    logic flag;
    trig_src_t trigger_source_field;
    conv_state_t cst;
    logic conv_start;
    logic done_evt;
    logic [9:0] result;
    logic temp_en;
    logic [11:0] pins;
    logic [11:0] gate_out;
  } state_t;

  state_t q;
  state_t n;

  // ************************************************************
  // decoding
  // ************************************************************

  function automatic logic [5:0] reg_index(input logic [7:0] addr);
    reg_index = addr[7:2];
  endfunction

  function automatic logic index_mapped(input logic [5:0] idx);
    index_mapped = (idx <= `IDX_PIN_VALUE);
  endfunction

  // ************************************************************
  // pin gating
  // ************************************************************

  logic [11:0] gate_all;
  logic [11:0] raw_all;
  logic [11:0] pin_masked;

  // bit 11 is the reference pin, bits 10:0 the analog pins
  assign gate_all = {
    q.analog_pin_input_gate_low[`GATE_LOW_REF_BIT],
    q.high_pin_gate_bits,
    q.analog_pin_input_gate_low[7:4],
    q.analog_pin_input_gate_low[2:0]
  };
  assign raw_all = {I_REF_PIN_RAW, I_PIN_RAW};

  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++)
    begin : g_gate
      assign pin_masked[gi] = raw_all[gi] & ~gate_all[gi];
    end
  endgenerate

  // ************************************************************
  // trigger
  // ************************************************************

  logic trig_pulse;

  // free running is fed by the completion event, not the sticky flag
  trig_edge_sel u_trig
  (
    .i_clk(I_MCLK),
    .i_rst(I_SYS_RST),
    .i_src({I_TRIG, q.done_evt}),
    .i_sel(q.trigger_source_field),
    .o_pulse(trig_pulse)
  );

  // ************************************************************
  // read mux
  // ************************************************************

  logic [5:0] rd_idx;
  logic [31:0] rd_data;

  assign rd_idx = reg_index(I_AXI.araddr);

  always_comb
  begin
    rd_data = 32'h0000_0000;
    case (rd_idx)
      `IDX_INPUT_SELECT:
      begin
        rd_data[5:0] = q.channel_select_field;
      end
      `IDX_GATE_LOW:
      begin
        rd_data[7:0] = q.analog_pin_input_gate_low;
      end
      `IDX_GATE_HIGH:
      begin
        rd_data[`GATE_HIGH_MSB:`GATE_HIGH_LSB] = q.high_pin_gate_bits;
      end
      `IDX_CONTROL:
      begin
        rd_data[`CTL_ENABLE_BIT] = q.converter_enable_bit;
        rd_data[`CTL_START_BIT] = q.start;
        rd_data[`CTL_AUTO_BIT] = q.auto_trig;
        rd_data[`CTL_FLAG_BIT] = q.flag;
        rd_data[`CTL_TSRC_MSB:`CTL_TSRC_LSB] = q.trigger_source_field;
      end
      `IDX_RESULT_LOW:
      begin
        rd_data[7:0] = q.result[7:0];
      end
      `IDX_RESULT_HIGH:
      begin
        rd_data[1:0] = q.result[9:`RESULT_HIGH_SHIFT];
      end
      `IDX_PIN_VALUE:
      begin
        rd_data[11:0] = q.pins;
      end
      default:
      begin
        rd_data = 32'h0000_0000;
      end
    endcase
  end

  // ************************************************************
  // next state
  // ************************************************************

  logic [5:0] wr_idx;
  logic do_write;
  logic [7:0] wb;

  assign wr_idx = reg_index(q.aw_addr);
  assign do_write = q.aw_full && q.w_full && !q.bvalid;
  assign wb = q.w_data[7:0];

  always_comb
  begin
    n = q;
    n.conv_start = 1'b0;
    n.done_evt = 1'b0;

    // response channels drop once taken
    if (q.bvalid && I_AXI.bready)
    begin
      n.bvalid = 1'b0;
    end
    if (q.rvalid && I_AXI.rready)
    begin
      n.rvalid = 1'b0;
    end

    // write address and data are captured independently
    if (I_AXI.awvalid && q.awready)
    begin
      n.aw_full = 1'b1;
      n.aw_addr = I_AXI.awaddr;
    end
    if (I_AXI.wvalid && q.wready)
    begin
      n.w_full = 1'b1;
      n.w_data = I_AXI.wdata;
      n.w_strb = I_AXI.wstrb;
    end

    if (do_write)
    begin
      n.aw_full = 1'b0;
      n.w_full = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = index_mapped(wr_idx) ? `RESP_OKAY : `RESP_SLVERR;
      // only byte lane 0 carries register bits
      if (q.w_strb[0])
      begin
        case (wr_idx)
          `IDX_INPUT_SELECT:
          begin
            n.channel_select_field = wb[5:0];
          end
          `IDX_GATE_LOW:
          begin
            n.analog_pin_input_gate_low = wb;
          end
          `IDX_GATE_HIGH:
          begin
            n.high_pin_gate_bits = wb[`GATE_HIGH_MSB:`GATE_HIGH_LSB];
          end
          `IDX_CONTROL:
          begin
            n.converter_enable_bit = wb[`CTL_ENABLE_BIT];
            n.auto_trig = wb[`CTL_AUTO_BIT];
            n.trigger_source_field = trig_src_t'(wb[`CTL_TSRC_MSB:`CTL_TSRC_LSB]);
            if (wb[`CTL_START_BIT])
            begin
              n.start = 1'b1;
            end
            // flag clears by writing one
            if (wb[`CTL_FLAG_BIT])
            begin
              n.flag = 1'b0;
            end
          end
          default:
          begin
            n.flag = n.flag;
          end
        endcase
      end
    end

    if (!q.rvalid && q.arready && I_AXI.arvalid)
    begin
      n.rvalid = 1'b1;
      n.rdata = rd_data;
      n.rresp = index_mapped(rd_idx) ? `RESP_OKAY : `RESP_SLVERR;
    end

    // conversion sequencing; completion is handled after the flag clear so it wins
    case (q.cst)
      CONV_IDLE:
      begin
        if (q.converter_enable_bit && (q.start || (q.auto_trig && trig_pulse)))
        begin
          n.conv_start = 1'b1;
          n.start = 1'b1;
          n.cst = CONV_BUSY;
        end
        // next enable, so a write of enable and start together keeps the start
        else if (!n.converter_enable_bit)
        begin
          n.start = 1'b0;
        end
      end
      CONV_BUSY:
      begin
        if (!q.converter_enable_bit)
        begin
          // disabling aborts; the converter result is then discarded
          n.start = 1'b0;
          n.cst = CONV_IDLE;
        end
        else if (I_CONV_DONE)
        begin
          n.result = I_CONV_RESULT;
          n.flag = 1'b1;
          n.start = 1'b0;
          n.done_evt = 1'b1;
          n.cst = CONV_IDLE;
        end
      end
      default:
      begin
        n.cst = CONV_IDLE;
      end
    endcase

    n.temp_en = (q.channel_select_field == `TEMP_SENSOR_CODE);
    n.pins = pin_masked;
    n.gate_out = gate_all;
    n.awready = !n.aw_full;
    n.wready = !n.w_full;
    n.arready = !n.rvalid;
  end

  // ************************************************************
  // registers
  // ************************************************************

  always_ff @(posedge I_MCLK or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      q <= '0;
      q.channel_select_field <= `RST_INPUT_SELECT;
      q.analog_pin_input_gate_low <= `RST_GATE_LOW;
      q.high_pin_gate_bits <= `RST_GATE_HIGH;
      q.result <= `RST_RESULT;
      q.cst <= CONV_IDLE;
      q.trigger_source_field <= TRIG_FREE_RUN;
    end
    else
    begin
      q <= n;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************

  // one driver for the whole response struct
  assign O_AXI = '{
    awready: q.awready,
    wready: q.wready,
    bresp: q.bresp,
    bvalid: q.bvalid,
    arready: q.arready,
    rdata: q.rdata,
    rresp: q.rresp,
    rvalid: q.rvalid
  };
  assign O_CONV_START = q.conv_start;
  assign O_CONV_BUSY = (q.cst == CONV_BUSY);
  assign O_CHANNEL = q.channel_select_field;
  assign O_TEMP_SENSOR_EN = q.temp_en;
  assign O_BUF_DISABLE = q.gate_out;
  assign O_PIN_VALUE = q.pins;

endmodule

/* testbench/adc_trigger_ctrl_chk.sv */
// assertion checker for the converter control block
`timescale 1ns/1ps
module adc_trigger_ctrl_chk
  import adc_ctrl_pkg::*;
(
  input wire logic I_MCLK,
  input wire logic I_SYS_RST,
  input wire axi_req_t I_AXI,
  input wire axi_rsp_t O_AXI,
  input wire logic I_CONV_DONE,
  input wire logic O_CONV_START,
  input wire logic O_CONV_BUSY,
  input wire logic [5:0] O_CHANNEL,
  input wire logic O_TEMP_SENSOR_EN,
  input wire logic [11:0] O_BUF_DISABLE,
  input wire logic [11:0] O_PIN_VALUE
);
  default clocking @(posedge I_MCLK);
  endclocking
  default disable iff (I_SYS_RST);
  sequence rd_wait_s;
    O_AXI.rvalid && !I_AXI.rready;
  endsequence
  temp_on_a: assert property ((O_CHANNEL == 6'h3F) [*2] |-> O_TEMP_SENSOR_EN)
    else $error("sensor enable low");
  temp_off_a: assert property ((O_CHANNEL != 6'h3F) [*2] |-> !O_TEMP_SENSOR_EN)
    else $error("sensor enable high");
  start_pulse_a: assert property (O_CONV_START |=> !O_CONV_START)
    else $error("start pulse too long");
  start_busy_a: assert property (O_CONV_START |-> O_CONV_BUSY)
    else $error("start without busy");
  busy_rise_a: assert property ($rose(O_CONV_BUSY) |-> O_CONV_START)
    else $error("busy without start");
  start_idle_a: assert property (O_CONV_START |-> !$past(O_CONV_BUSY))
    else $error("start while busy");
  done_idle_a: assert property (O_CONV_BUSY && I_CONV_DONE |=> !O_CONV_BUSY)
    else $error("busy after done");
  pin_gate_a: assert property ($stable(O_BUF_DISABLE) |->
    (O_PIN_VALUE[10:0] & O_BUF_DISABLE[10:0]) == 11'h000)
    else $error("gated pin reads one");
  ref_gate_a: assert property ($stable(O_BUF_DISABLE) && O_BUF_DISABLE[11] |->
    !O_PIN_VALUE[11])
    else $error("gated reference pin reads one");
  rdata_hold_a: assert property (rd_wait_s |=> O_AXI.rvalid && $stable(O_AXI.rdata))
    else $error("read data dropped");
endmodule
bind adc_trigger_ctrl adc_trigger_ctrl_chk chk (
  .I_MCLK(I_MCLK),
  .I_SYS_RST(I_SYS_RST),
  .I_AXI(I_AXI),
  .O_AXI(O_AXI),
  .I_CONV_DONE(I_CONV_DONE),
  .O_CONV_START(O_CONV_START),
  .O_CONV_BUSY(O_CONV_BUSY),
  .O_CHANNEL(O_CHANNEL),
  .O_TEMP_SENSOR_EN(O_TEMP_SENSOR_EN),
  .O_BUF_DISABLE(O_BUF_DISABLE),
  .O_PIN_VALUE(O_PIN_VALUE)
);

/* testbench/tb_adc_trigger_ctrl.sv */
// self-checking testbench for the converter control block
`timescale 1ns/1ps
`include "adc_ctrl_params.svh"
module tb_adc_trigger_ctrl
  import adc_ctrl_pkg::*;
;
  logic clk;
  logic rst;
  axi_req_t req;
  axi_rsp_t rsp;
  trig_in_t trig;
  logic done;
  logic [9:0] res;
  logic [10:0] raw;
  logic rref;
  logic start;
  logic [5:0] chan;
  logic temp_en;
  logic [11:0] bufd;
  logic [11:0] pinv;
  logic [31:0] rv;
  logic [31:0] lo;
  logic [1:0] rr;
  int n_errors = 0;
  int n_tests = 0;
  int n_start = 0;
  adc_trigger_ctrl dut (
    .I_MCLK(clk),
    .I_SYS_RST(rst),
    .I_AXI(req),
    .O_AXI(rsp),
    .I_TRIG(trig),
    .I_CONV_DONE(done),
    .I_CONV_RESULT(res),
    .I_PIN_RAW(raw),
    .I_REF_PIN_RAW(rref),
    .O_CONV_START(start),
    .O_CONV_BUSY(),
    .O_CHANNEL(chan),
    .O_TEMP_SENSOR_EN(temp_en),
    .O_BUF_DISABLE(bufd),
    .O_PIN_VALUE(pinv)
  );
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    if (start === 1'h1)
      n_start <= n_start + 1;
  end
  // ****************
  // bus, converter and checking tasks
  // ****************
  task automatic end_of_test();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic tmo();
    cmp("bus wait", 32'h1, 32'h0);
    end_of_test();
  endtask
  // bready stays high and rready is high except during slow reads, so answers are taken at once
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    int n;
    req.awaddr <= a;
    req.awvalid <= 1'h1;
    req.wdata <= {24'h000000, d};
    req.wstrb <= 4'hF;
    req.wvalid <= 1'h1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'h0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'h0;
      if (rsp.bvalid === 1'h1)
        break;
    end
    if (n == 50)
      tmo();
    cmp("bresp", {30'h0, er}, {30'h0, rsp.bresp});
  endtask
  // slow holds rready low until rvalid shows, so the slave must keep its answer
  task automatic rd(input logic [7:0] a, input bit slow = 1'b0);
    int n;
    req.araddr <= a;
    req.arvalid <= 1'h1;
    if (slow)
      req.rready <= 1'h0;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'h0;
      if (rsp.rvalid === 1'h1 && req.rready)
        break;
      if (rsp.rvalid === 1'h1)
        req.rready <= 1'h1;
    end
    if (n == 50)
      tmo();
    rv = rsp.rdata;
    rr = rsp.rresp;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    rd(a);
    cmp("rdata", exp, rv);
  endtask
  // a quiet window is the only way to see that no start came
  task automatic wst(input int k);
    int s;
    int n;
    s = n_start;
    for (n = 0; n < 8 && n_start == s; n++)
      @(posedge clk);
    @(posedge clk);
    cmp("starts", k, n_start - s);
  endtask
  task automatic fin(input logic [9:0] v);
    done <= 1'h1;
    res <= v;
    @(posedge clk);
    done <= 1'h0;
    @(posedge clk);
  endtask
  // ****************
  // main sequence
  // ****************
  initial
  begin
    req = '0;
    req.bready = 1'h1;
    req.rready = 1'h1;
    trig = '0;
    done = 1'h0;
    res = 10'h000;
    raw = 11'h5A5;
    rref = 1'h1;
    rst = 1'h1;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    repeat (2) @(posedge clk);
    for (int i = 0; i < 6; i++)
      rdc(8'(4 * i), 32'h0);
    rdc(8'h18, 32'hDA5);
    rd(8'h1C);
    cmp("rresp", `RESP_SLVERR, rr);
    wr(8'h1C, 8'hFF, `RESP_SLVERR);
    $display("test map end");
    wr(8'h00, 8'h3F, `RESP_OKAY);
    rdc(8'h00, 32'h3F);
    cmp("temp_en", 32'h1, temp_en);
    cmp("channel", 32'h3F, chan);
    wr(8'h00, 8'h3E, `RESP_OKAY);
    repeat (2) @(posedge clk);
    cmp("temp_en", 32'h0, temp_en);
    $display("test channel end");
    wr(8'h04, 8'h28, `RESP_OKAY);
    wr(8'h08, 8'hAF, `RESP_OKAY);
    rdc(8'h08, 32'hA0);
    rdc(8'h04, 32'h28);
    raw <= 11'h7FF;
    repeat (3) @(posedge clk);
    cmp("buf_dis", 32'hD10, bufd);
    cmp("pin_val", 32'h2EF, pinv);
    rdc(8'h18, 32'h2EF);
    $display("test gate end");
    for (int s = 1; s < 8; s++)
    begin
      wr(8'h0C, 8'hB0 | 8'(s), `RESP_OKAY);
      trig <= ~(7'h01 << (s - 1));
      wst(0);
      trig <= '1;
      wst(1);
      fin(10'(s * 100 + 5));
      rdc(8'h0C, 32'hB0 | s);
      trig <= '0;
    end
    wr(8'h0C, 8'h21, `RESP_OKAY);
    trig <= 7'h01;
    wst(0);
    trig <= '0;
    wr(8'h0C, 8'hA0, `RESP_OKAY);
    wst(0);
    rdc(8'h0C, 32'hB0);
    wr(8'h0C, 8'hE0, `RESP_OKAY);
    wst(1);
    fin(10'h155);
    wst(1);
    wr(8'h0C, 8'h10, `RESP_OKAY);
    rdc(8'h0C, 32'h0);
    $display("test trigger end");
    wr(8'h00, 8'h3F, `RESP_OKAY);
    wr(8'h0C, 8'hD0, `RESP_OKAY);
    wst(1);
    fin(10'h2C5);
    rd(8'h10, 1'b1);
    lo = rv;
    rdc(8'h14, 32'h2);
    cmp("result", 32'h2C5, (rv << 8) | lo);
    $display("test result end");
    end_of_test();
  end
endmodule
